/* File: hw/seqcfg_top.v */
// step nine configuration register with axi4-lite access and a two-step sequencer walk
// Behaviour
// - bit 15 set enables step nine; clear disables it.
// - bits 14:13 pick gain: 00b gives 1, 01b gives 2, 10b/11b give 4.
// - bit 4 picks negative input: zero ground b, one input seven b.
// - bits 3:0 codes 0000b-0111b pick external inputs zero to seven b.
// - 1000b temperature sensor, 1001b internal short; negative input automatic.
// - 1010b test dac, 1100b io rail/4, 1101b analog rail/4; negative automatic.
// - 1110b analog power/103, 1111b digital power/103; negative automatic.
// - automatic negative codes make the negative select bit ignored.
// - step nine register sits at index D9h and resets to 0009h.
`timescale 1ns/100ps
`default_nettype none
`include "seqcfg_defines.vh"
module seqcfg_top #(
	parameter CONV_CYC = `SEQCFG_CONV_CYC
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         conv_active,
	output reg         conv_step,
	output reg  [1:0]  conv_gain,
	output reg  [3:0]  conv_pos,
	output reg  [2:0]  conv_neg
);
	localparam ST_IDLE = 2'h0;
	localparam ST_PICK = 2'h1;
	localparam ST_CONV = 2'h2;
	localparam [1:0] RESP_OKAY = 2'h0;
	localparam [1:0] RESP_SLVERR = 2'h2;

	reg  [15:0] step9_ff;
	reg  [15:0] step10_ff;
	reg         run_ff;
	reg         cont_ff;
	reg  [1:0]  state_ff;
	reg  [1:0]  nxt_state;
	reg         cur_ff;
	reg         nxt_cur;
	reg         tried_ff;
	reg         nxt_tried;
	reg  [15:0] cnt_ff;
	reg  [15:0] nxt_cnt;
	reg  [11:0] aw_addr_ff;
	reg         aw_got_ff;
	reg  [31:0] w_data_ff;
	reg  [3:0]  w_strb_ff;
	reg         w_got_ff;
	reg  [7:0]  done_cnt_ff;

	wire        s9_en;
	wire [1:0]  s9_gain;
	wire [3:0]  s9_pos;
	wire [2:0]  s9_neg;
	wire        s10_en;
	wire [1:0]  s10_gain;
	wire [3:0]  s10_pos;
	wire [2:0]  s10_neg;

	seqcfg_step_decode u_dec9 (
		.cfg_word (step9_ff),
		.step_en  (s9_en),
		.gain_sel (s9_gain),
		.pos_sel  (s9_pos),
		.neg_sel  (s9_neg)
	);

	seqcfg_step_decode u_dec10 (
		.cfg_word (step10_ff),
		.step_en  (s10_en),
		.gain_sel (s10_gain),
		.pos_sel  (s10_pos),
		.neg_sel  (s10_neg)
	);

	// byte-lane merge of a write into a 16-bit register, reserved bits held at zero
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		reg   [15:0] tmp;
		begin
			tmp = old;
			if (strb[0]) begin
				tmp[7:0] = data[7:0];
			end
			if (strb[1]) begin
				tmp[15:8] = data[15:8];
			end
			merge16 = tmp & `SEQCFG_WR_MASK;
		end
	endfunction

	function addr_known;
		input [11:0] a;
		begin
			addr_known = (a == `SEQCFG_STEP9_ADDR) || (a == `SEQCFG_STEP10_ADDR) ||
				(a == `SEQCFG_SEQ_CTRL_ADDR) || (a == `SEQCFG_SEQ_STAT_ADDR);
		end
	endfunction

	wire do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;
	wire [11:0] wa = {aw_addr_ff[11:2], 2'b00};
	wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
	wire start_pulse = do_write && (wa == `SEQCFG_SEQ_CTRL_ADDR) && w_strb_ff[0] &&
		w_data_ff[0];

	// write channel: address and data taken in either order, response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			aw_addr_ff    <= 12'h000;
			w_data_ff     <= 32'h00000000;
			w_strb_ff     <= 4'h0;
			step9_ff      <= `SEQCFG_STEP9_RST;
			step10_ff     <= `SEQCFG_STEP10_RST;
			cont_ff       <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_ff    <= s_axi_awaddr;
				aw_got_ff     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_ff    <= s_axi_wdata;
				w_strb_ff    <= s_axi_wstrb;
				w_got_ff     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_known(wa) ? RESP_OKAY : RESP_SLVERR;
				if (wa == `SEQCFG_STEP9_ADDR) begin
					step9_ff <= merge16(step9_ff, w_data_ff, w_strb_ff);
				end
				if (wa == `SEQCFG_STEP10_ADDR) begin
					step10_ff <= merge16(step10_ff, w_data_ff, w_strb_ff);
				end
				if ((wa == `SEQCFG_SEQ_CTRL_ADDR) && w_strb_ff[0]) begin
					cont_ff <= w_data_ff[1];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read channel: one outstanding read, answered the cycle after it is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= addr_known(ra) ? RESP_OKAY : RESP_SLVERR;
			case (ra)
				`SEQCFG_STEP9_ADDR: s_axi_rdata <= {16'h0000, step9_ff};
				`SEQCFG_STEP10_ADDR: s_axi_rdata <= {16'h0000, step10_ff};
				`SEQCFG_SEQ_CTRL_ADDR: s_axi_rdata <= {30'h00000000, cont_ff, 1'b0};
				`SEQCFG_SEQ_STAT_ADDR: s_axi_rdata <= {16'h0000, done_cnt_ff,
					3'h0, conv_step, conv_active, state_ff, run_ff};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// sequencer walk over steps nine and ten, skipping disabled steps
	always @* begin
		nxt_state = state_ff;
		nxt_cur   = cur_ff;
		nxt_tried = tried_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_pulse) begin
					nxt_state = ST_PICK;
					nxt_cur   = 1'b0;
					nxt_tried = 1'b0;
				end
			end
			ST_PICK: begin
				if ((cur_ff ? s10_en : s9_en)) begin
					nxt_state = ST_CONV;
					nxt_cnt   = CONV_CYC[15:0];
				end else if (tried_ff && !cur_ff) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_cur   = ~cur_ff;
					nxt_tried = cur_ff ? 1'b1 : tried_ff;
					if (cur_ff && !cont_ff) begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_CONV: begin
				if (cnt_ff == 16'h0001) begin
					nxt_cur   = ~cur_ff;
					nxt_tried = 1'b0;
					nxt_state = (cur_ff && !cont_ff) ? ST_IDLE : ST_PICK;
				end else begin
					nxt_cnt = cnt_ff - 16'h0001;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff    <= ST_IDLE;
			cur_ff      <= 1'b0;
			tried_ff    <= 1'b0;
			cnt_ff      <= 16'h0000;
			run_ff      <= 1'b0;
			done_cnt_ff <= 8'h00;
			conv_active <= 1'b0;
			conv_step   <= 1'b0;
			conv_gain   <= `SEQCFG_GAIN_X1;
			conv_pos    <= 4'h0;
			conv_neg    <= `SEQCFG_NEG_GND;
		end else begin
			state_ff    <= nxt_state;
			cur_ff      <= nxt_cur;
			tried_ff    <= nxt_tried;
			cnt_ff      <= nxt_cnt;
			run_ff      <= (nxt_state != ST_IDLE);
			conv_active <= (nxt_state == ST_CONV);
			if ((state_ff == ST_CONV) && (cnt_ff == 16'h0001)) begin
				done_cnt_ff <= done_cnt_ff + 8'h01;
			end
			if ((state_ff == ST_PICK) && (nxt_state == ST_CONV)) begin
				// latch the step's own selections for the whole conversion
				conv_step <= cur_ff;
				conv_gain <= cur_ff ? s10_gain : s9_gain;
				conv_pos  <= cur_ff ? s10_pos : s9_pos;
				conv_neg  <= cur_ff ? s10_neg : s9_neg;
			end
		end
	end
endmodule // seqcfg_top
`default_nettype wire

/* File: hw/seqcfg_defines.vh */
// register offsets, field positions, reset values and timing for the step configuration block
`ifndef SEQCFG_DEFINES_VH
`define SEQCFG_DEFINES_VH
`define SEQCFG_STEP9_IDX       8'hD9
`define SEQCFG_STEP10_IDX      8'hDA
`define SEQCFG_STEP9_ADDR      12'h364
`define SEQCFG_STEP10_ADDR     12'h368
`define SEQCFG_SEQ_CTRL_ADDR   12'h400
`define SEQCFG_SEQ_STAT_ADDR   12'h404
`define SEQCFG_STEP9_RST       16'h0009
`define SEQCFG_STEP10_RST      16'h000A
`define SEQCFG_EN_BIT          15
`define SEQCFG_GAIN_HI         14
`define SEQCFG_GAIN_LO         13
`define SEQCFG_NEG_BIT         4
`define SEQCFG_POS_HI          3
`define SEQCFG_POS_LO          0
`define SEQCFG_WR_MASK         16'hE01F
`define SEQCFG_GAIN_X1         2'h0
`define SEQCFG_GAIN_X2         2'h1
`define SEQCFG_GAIN_X4         2'h2
`define SEQCFG_NEG_GND         3'h0
`define SEQCFG_NEG_IN7         3'h1
`define SEQCFG_NEG_AUTO        3'h2
`define SEQCFG_CONV_NS         1000
`define SEQCFG_CLK_MHZ         25
`define SEQCFG_CONV_CYC        ((`SEQCFG_CONV_NS * `SEQCFG_CLK_MHZ + 999) / 1000)
`endif

/* File: hw/seqcfg_step_decode.v */
// decoder from one step configuration word to the converter selections it implies
`timescale 1ns/100ps
`default_nettype none
`include "seqcfg_defines.vh"
module seqcfg_step_decode (
	input  wire [15:0] cfg_word,
	output reg         step_en,
	output reg  [1:0]  gain_sel,
	output reg  [3:0]  pos_sel,
	output reg  [2:0]  neg_sel
);
	always @* begin
		step_en = cfg_word[`SEQCFG_EN_BIT];
		case (cfg_word[`SEQCFG_GAIN_HI:`SEQCFG_GAIN_LO])
			2'h0: gain_sel = `SEQCFG_GAIN_X1;
			2'h1: gain_sel = `SEQCFG_GAIN_X2;
			default: gain_sel = `SEQCFG_GAIN_X4;
		endcase
		pos_sel = cfg_word[`SEQCFG_POS_HI:`SEQCFG_POS_LO];
		// codes 1000b and above route the negative input internally
		if (pos_sel[3]) begin
			neg_sel = `SEQCFG_NEG_AUTO;
		end else if (cfg_word[`SEQCFG_NEG_BIT]) begin
			neg_sel = `SEQCFG_NEG_IN7;
		end else begin
			neg_sel = `SEQCFG_NEG_GND;
		end
	end
endmodule // seqcfg_step_decode
`default_nettype wire

/* File: test/asc_chk_sva.sv */
// assertion checker for the step configuration block ports
`timescale 1ns/100ps
`default_nettype none
module asc_chk #(
	parameter CONV_CYC = 25
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        conv_active,
	input wire logic [1:0]  conv_gain,
	input wire logic [3:0]  conv_pos,
	input wire logic [2:0]  conv_neg
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	chk_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read answer missing");
	chk_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
		else $error("write answer missing");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during answer");
	chk_gain_code: assert property (conv_active |-> conv_gain != 2'h3)
		else $error("bad gain code");
	chk_neg_auto: assert property (conv_active && conv_pos[3] |-> conv_neg == 3'h2)
		else $error("negative input not automatic");
	chk_neg_pick: assert property (conv_active && !conv_pos[3] |-> conv_neg < 3'h2)
		else $error("negative input not chosen");
endmodule // asc_chk
bind seqcfg_top asc_chk #(.CONV_CYC(CONV_CYC)) u_chk (.*);
`default_nettype wire

/* File: test/asc_host.sv */
// host model: axi4-lite master driving the register bus
`timescale 1ns/100ps
`default_nettype none
module asc_host (
	input  wire logic        aclk,
	output logic      [11:0] s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic      [3:0]  s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [11:0] s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // asc_host
`default_nettype wire

/* File: test/test_adc_sequencer_step_config.sv */
// self-checking testbench for the step configuration block
`timescale 1ns/100ps
`default_nettype none
`include "seqcfg_defines.vh"
module test_adc_sequencer_step_config;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, w;
	logic [3:0]  s_axi_wstrb, conv_pos;
	logic [2:0]  conv_neg;
	logic [1:0]  s_axi_bresp, s_axi_rresp, conv_gain, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        conv_active, conv_step;
	int          miscompares = 0, comparisons = 0, seed = 9, cyc = 0, k;
	seqcfg_top #(.CONV_CYC(8)) dut (.*);
	asc_host host (.*);
	always #20 aclk = ~aclk;
	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			wrap_up;
		end
	end
	function automatic logic [1:0] exp_gain(input logic [31:0] v);
		return v[14] ? 2'h2 : {1'b0, v[13]};
	endfunction
	function automatic logic [2:0] exp_neg(input logic [31:0] v);
		return v[3] ? 3'h2 : {2'h0, v[4]};
	endfunction
	// wait for conversion activity a, on step s unless any step will do
	task await(input logic a, input logic s, input bit any);
		k = 0;
		while (k < 200 && !(conv_active === a && (any || conv_step === s))) begin
			@(posedge aclk);
			k++;
		end
		if (k >= 200) begin
			miscompares++;
			wrap_up;
		end
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		host.rd(`SEQCFG_STEP9_ADDR, d, r);
		check("step nine reset", d, 32'h9);
		host.rd(`SEQCFG_STEP10_ADDR, d, r);
		check("step ten reset", d, 32'hA);
		host.rd(12'h010, d, r);
		check("unmapped read resp", r, 2'h2);
		host.wr(12'h010, 32'hFFFF, r);
		check("unmapped write resp", r, 2'h2);
		for (int i = 0; i < 8; i++) begin
			w = $random(seed);
			host.wr(`SEQCFG_STEP9_ADDR, w, r);
			check("step nine write resp", r, 2'h0);
			host.rd(`SEQCFG_STEP9_ADDR, d, r);
			check("step nine readback", d, w & 32'hE01F);
		end
		host.wr(`SEQCFG_STEP10_ADDR, 32'h800A, r);
		for (int i = 0; i < 16; i++) begin
			w = $random(seed);
			w[15] = (i != 5);
			w[3:0] = i;
			host.wr(`SEQCFG_STEP9_ADDR, w, r);
			host.wr(`SEQCFG_SEQ_CTRL_ADDR, 32'h1, r);
			await(1'b1, 1'b0, 1'b1);
			check("first step", conv_step, !w[15]);
			if (w[15]) begin
				check("pos input", conv_pos, w[3:0]);
				check("gain", conv_gain, exp_gain(w));
				check("neg input", conv_neg, exp_neg(w));
			end
			await(1'b1, 1'b1, 1'b0);
			check("step ten pos", conv_pos, 4'hA);
			await(1'b0, 1'b0, 1'b1);
		end
		// continuous mode loops back to step nine; once it is cleared the walk stops after step ten
		host.wr(`SEQCFG_SEQ_CTRL_ADDR, 32'h3, r);
		await(1'b1, 1'b1, 1'b0);
		await(1'b1, 1'b0, 1'b0);
		check("loop step pos", conv_pos, w[3:0]);
		host.wr(`SEQCFG_SEQ_CTRL_ADDR, 32'h0, r);
		await(1'b1, 1'b1, 1'b0);
		await(1'b0, 1'b0, 1'b1);
		host.rd(`SEQCFG_SEQ_STAT_ADDR, d, r);
		check("sequencer idle", d[0], 1'b0);
		// reset in mid-run while converting restores the register defaults
		host.wr(`SEQCFG_SEQ_CTRL_ADDR, 32'h3, r);
		await(1'b1, 1'b0, 1'b1);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		check("reset stops conversion", conv_active, 1'b0);
		aresetn <= 1'b1;
		host.rd(`SEQCFG_STEP9_ADDR, d, r);
		check("step nine reset again", d, 32'h9);
		host.rd(`SEQCFG_SEQ_CTRL_ADDR, d, r);
		check("continuous cleared", d, 32'h0);
		wrap_up;
	end
endmodule // test_adc_sequencer_step_config
`default_nettype wire
